//--- byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("byte_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic do_wr;
  logic do_rd;

  // full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid_o = (wr_r != rd_r);
  assign out_data_o = mem_r[rd_r[AW-1:0]];
  assign do_wr = ce_i && in_valid_i && in_ready_o;
  assign do_rd = ce_i && out_valid_o && out_ready_i;

  // storage, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (do_wr)
      mem_r[wr_r[AW-1:0]] <= in_data_i;
  end

  // pointers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (do_wr)
        wr_r <= wr_r + (AW+1)'(1);
      if (do_rd)
        rd_r <= rd_r + (AW+1)'(1);
    end
  end
endmodule : byte_fifo

//--- lcd_shift_pkg.sv
package lcd_shift_pkg;
  // shifted byte layout
  localparam int NIBBLE_LSB = 0;
  localparam int NIBBLE_MSB = 3;
  localparam int SPARE_A_BIT = 4;
  localparam int SPARE_B_BIT = 5;
  localparam int SELECT_BIT = 6;
  localparam int STROBE_BIT = 7;
  localparam int BYTE_BITS = 8;
  localparam int NIBBLE_BITS = 4;
  // widest supported display, characters
  localparam int MAX_CHARS = 80;
  // writes per nibble expected from the master
  localparam int XFERS_PER_NIBBLE = 3;
  // reset values and counter increments
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [1:0] PTR_ONE = 2'h1;
endpackage : lcd_shift_pkg

//--- lcd_shift_port.sv
`timescale 1ns/1ps
module lcd_shift_port
  import lcd_shift_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // spi slave pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic ss_n_i,
  // board enable switch
  input wire logic port_enable_i,
  // lcd side
  output logic [3:0] lcd_upper_nibble_lines_o,
  output logic [3:0] lcd_lower_nibble_lines_o,
  output logic cmd_data_select_o,
  output logic lcd_enable_o,
  output logic spare_out_a_o,
  output logic spare_out_b_o,
  // status
  output logic frame_error_o,
  output logic [1:0] xfer_phase_o
);
  initial
  begin
    if (FIFO_DEPTH != 4)
      $error("lcd_shift_port: fifo depth must be 4");
  end

  // two-stage synchronisers for the pins
  logic [1:0] sck_s_r, mosi_s_r, ss_s_r, en_s_r;
  logic sck_d_r;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sck_s_r <= '0;
      mosi_s_r <= '0;
      ss_s_r <= '1; // select idles released, so no false release after reset
      en_s_r <= '0;
      sck_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sck_s_r <= {sck_s_r[0], sck_i};
      mosi_s_r <= {mosi_s_r[0], mosi_i};
      ss_s_r <= {ss_s_r[0], ss_n_i};
      en_s_r <= {en_s_r[0], port_enable_i};
      sck_d_r <= sck_s_r[1];
    end
  end

  logic sck_rise, sel_n, sel_n_d_r, ss_release;
  assign sck_rise = sck_s_r[1] && !sck_d_r;
  assign sel_n = ss_s_r[1];
  assign ss_release = sel_n && !sel_n_d_r;

  // shift only while selected, msb first
  logic [7:0] shift_r;
  logic [3:0] count_r;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      shift_r <= BYTE_RESET;
      count_r <= COUNT_ZERO;
      sel_n_d_r <= 1'b1;
    end
    else if (ce_i)
    begin
      sel_n_d_r <= sel_n;
      if (sel_n)
        count_r <= COUNT_ZERO;
      else if (sck_rise)
      begin
        shift_r <= {shift_r[BYTE_BITS-2:0], mosi_s_r[1]};
        if (count_r != 4'(BYTE_BITS + 1)) // stop past eight so a ninth edge spoils the byte
          count_r <= count_r + COUNT_ONE;
      end
    end
  end

  // a byte is whole only with exactly eight edges in the frame
  logic byte_ok, push;
  assign byte_ok = ss_release && (count_r == 4'(BYTE_BITS));
  assign push = byte_ok && en_s_r[1];

  logic fifo_rdy, fifo_vld;
  logic [7:0] fifo_q;
  // lcd side takes one byte per cycle; ce gates both ends, so the fifo never holds more than one byte
  byte_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .in_data_i(shift_r),
    .out_valid_o(fifo_vld),
    .out_ready_i(1'b1),
    .out_data_o(fifo_q)
  );

  // parallel outputs, all bits loaded in one edge
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      lcd_upper_nibble_lines_o <= NIBBLE_ZERO;
      cmd_data_select_o <= 1'b0;
      lcd_enable_o <= 1'b0;
      spare_out_a_o <= 1'b0;
      spare_out_b_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!en_s_r[1])
        lcd_enable_o <= 1'b0;
      else if (fifo_vld)
      begin
        lcd_upper_nibble_lines_o <= fifo_q[NIBBLE_MSB:NIBBLE_LSB];
        spare_out_a_o <= fifo_q[SPARE_A_BIT];
        spare_out_b_o <= fifo_q[SPARE_B_BIT];
        cmd_data_select_o <= fifo_q[SELECT_BIT];
        lcd_enable_o <= fifo_q[STROBE_BIT];
      end
    end
  end

  // lower lines never driven high; no read path back to the master
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      lcd_lower_nibble_lines_o <= NIBBLE_ZERO;
    else
      lcd_lower_nibble_lines_o <= NIBBLE_ZERO;
  end

  // phase tracker of the three-byte write, for software diagnosis only
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      xfer_phase_o <= '0;
      frame_error_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (ss_release && !byte_ok)
        frame_error_o <= 1'b1;
      else if (push && !fifo_rdy)
        frame_error_o <= 1'b1;
      if (push)
      begin
        if (xfer_phase_o == 2'(XFERS_PER_NIBBLE - 1))
          xfer_phase_o <= '0;
        else
          xfer_phase_o <= xfer_phase_o + PTR_ONE;
      end
    end
  end

  // checks
  a_lower_held_low: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 lcd_lower_nibble_lines_o == NIBBLE_ZERO) else $error("lower lines driven");
  a_disable_kills_strobe: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && !en_s_r[1]) |=> !lcd_enable_o) else $error("strobe while disabled");
  a_no_push_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
    !en_s_r[1] |-> !push) else $error("byte taken while disabled");
  a_push_needs_byte: assert property (@(posedge clk_i) disable iff (reset_i)
    push |-> (count_r == 4'(BYTE_BITS)) && $rose(sel_n)) else $error("partial byte");
  a_outputs_from_fifo: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && en_s_r[1] && fifo_vld) |=>
    lcd_upper_nibble_lines_o == $past(fifo_q[NIBBLE_MSB:NIBBLE_LSB])
    && cmd_data_select_o == $past(fifo_q[SELECT_BIT])
    && lcd_enable_o == $past(fifo_q[STROBE_BIT]))
    else $error("outputs not loaded");
  a_spare_follow: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && en_s_r[1] && fifo_vld) |=> spare_out_a_o == $past(fifo_q[SPARE_A_BIT])
    && spare_out_b_o == $past(fifo_q[SPARE_B_BIT])) else $error("spare mismatch");
  a_idle_no_count: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && sel_n) |=> count_r == COUNT_ZERO) else $error("count outside frame");
  a_phase_wraps: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && push && xfer_phase_o == 2'(XFERS_PER_NIBBLE - 1)) |=> xfer_phase_o == '0)
    else $error("phase wrap");
  // taken byte into an empty queue shows on the lcd lines two edges later
  sequence s_take_empty;
    ce_i && push && fifo_rdy && !fifo_vld;
  endsequence
  sequence s_drain_on;
    ce_i && en_s_r[1];
  endsequence
  a_byte_reaches_lcd: assert property (@(posedge clk_i) disable iff (reset_i)
    s_take_empty ##1 s_drain_on |=>
    lcd_upper_nibble_lines_o == $past(shift_r[NIBBLE_MSB:NIBBLE_LSB], 2)
    && cmd_data_select_o == $past(shift_r[SELECT_BIT], 2)) else $error("byte not shown");
endmodule : lcd_shift_port

//--- spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
  // spi pins toward the port
  output logic sck_o,
  output logic mosi_o,
  output logic ss_n_o
);
  // idle: clock parked low, select released
  initial
  begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end
  // one framed byte, msb first, mode 0; short counts only for fault tests
  task automatic xfer(input logic [7:0] b, input int nbits);
    ss_n_o = 1'b0;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      mosi_o = b[i];
      #400 sck_o = 1'b1;
      #400 sck_o = 1'b0;
    end
    #400 ss_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not keep the last bit
  endtask : xfer
endmodule : spi_master_model

//--- tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import lcd_shift_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic port_enable_i = 1'b1;
  logic sck, mosi, ss_n, sel, stb, spa, spb, ferr;
  logic [3:0] upper, lower;
  logic [1:0] phase;
  logic [31:0] rng = 32'h2E2D;
  logic [7:0] exp_byte = 8'h00;
  logic [7:0] b;
  int failures = 0;
  int checks_done = 0;
  int phase_cnt = 0;
  // 10 MHz system clock
  always #50 clk_i = ~clk_i;
  spi_master_model u_master (.sck_o(sck), .mosi_o(mosi), .ss_n_o(ss_n));
  lcd_shift_port u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .sck_i(sck), .mosi_i(mosi), .ss_n_i(ss_n), .port_enable_i(port_enable_i),
    .lcd_upper_nibble_lines_o(upper), .lcd_lower_nibble_lines_o(lower),
    .cmd_data_select_o(sel), .lcd_enable_o(stb),
    .spare_out_a_o(spa), .spare_out_b_o(spb),
    .frame_error_o(ferr), .xfer_phase_o(phase)
  );
  // xorshift source for nibble and select values
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // compare every lcd line with the bench model
  task automatic check_outputs;
    `CHK(upper, exp_byte[3:0])
    `CHK(lower, NIBBLE_ZERO)
    `CHK(spa, exp_byte[SPARE_A_BIT])
    `CHK(spb, exp_byte[SPARE_B_BIT])
    `CHK(sel, exp_byte[SELECT_BIT])
    `CHK(stb, exp_byte[STROBE_BIT] & port_enable_i)
    `CHK(phase, 2'(phase_cnt))
  endtask : check_outputs
  // one frame, then let the sync, fifo and output stages settle
  task automatic send(input logic [7:0] v, input int nbits);
    u_master.xfer(v, nbits);
    repeat (8) @(posedge clk_i);
    #1;
    if (nbits == BYTE_BITS && port_enable_i)
    begin
      exp_byte = v;
      phase_cnt = (phase_cnt + 1) % XFERS_PER_NIBBLE;
    end
    check_outputs();
  endtask : send
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // hang guard, far beyond the roughly 170 us of traffic
  initial
  begin
    #2000000;
    failures++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check_outputs();
    // random nibble writes, three frames each with strobe 0,1,0
    for (int n = 0; n < 6; n++)
    begin
      rng = xs(rng);
      b = {1'b0, rng[6:0]};
      send(b, 8);
      send(b | 8'h80, 8);
      send(b, 8);
    end
    // strobe left high, then switch off: strobe drops, traffic ignored
    send(8'hC5, 8);
    port_enable_i = 1'b0;
    exp_byte[STROBE_BIT] = 1'b0; // forced-low strobe stays low until the next byte
    repeat (6) @(posedge clk_i);
    #1;
    check_outputs();
    send(8'h3A, 8);
    port_enable_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    `CHK(ferr, 1'b0)
    // a seven-bit frame is dropped and flagged
    send(8'h5B, 7);
    `CHK(ferr, 1'b1)
    send(8'h4E, 8);
    report_and_stop();
  end
endmodule : tb
